// ==== hw/uart_pwr_emu_ctrl.v ====
// power and emulation control for a uart, with an axi4-lite register slave
// assumes: tx_word_active comes from the transmitter on aclk; emu_halt_req
// is asynchronous and is synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "uart_pwr_emu_defines.vh"

module uart_pwr_emu_ctrl #(
    parameter ADDR_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire emu_halt_req,
    input wire tx_word_active,
    output reg tx_enable,
    output reg tx_hold_reset,
    output reg rx_enable,
    output reg rx_hold_reset,
    output reg tx_start_allow,
    output reg rx_allow,
    output reg event_allow,
    output reg halted
);

    // ----------------------------------------------------------------
    // halt state machine encoding
    // ----------------------------------------------------------------
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_DRAIN = 3'b010;
    localparam [2:0] ST_HALT = 3'b100;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg tx_en_q;
    reg rx_en_q;
    reg free_q;
    wire halt_req_s;
    wire aw_held;
    wire w_held;
    wire [ADDR_W-1:0] aw_addr_q;
    wire [35:0] w_beat_q;
    wire [31:0] w_data_q;
    wire [3:0] w_strb_q;
    wire wr_fire;
    wire wr_ctrl;
    wire wr_status;
    wire [ADDR_W-1:0] off_ctrl;
    wire [ADDR_W-1:0] off_status;
    wire [31:0] ctrl_rd;
    wire [31:0] status_rd;
    wire halted_d;

    assign off_ctrl = `PEC_OFFSET_CTRL;
    assign off_status = `PEC_OFFSET_STATUS;
    assign w_data_q = w_beat_q[31:0];
    assign w_strb_q = w_beat_q[35:32];

    // ----------------------------------------------------------------
    // halt request synchroniser
    // ----------------------------------------------------------------
    sync_2ff u_halt_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(emu_halt_req),
        .sync_out(halt_req_s)
    );

    // ----------------------------------------------------------------
    // write address and data capture, taken in either order
    // ----------------------------------------------------------------
    axil_channel_hold #(
        .WIDTH(ADDR_W)
    ) u_aw_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .valid(s_axi_awvalid),
        .payload(s_axi_awaddr),
        .ready(s_axi_awready),
        .held(aw_held),
        .payload_q(aw_addr_q),
        .consume(wr_fire)
    );

    axil_channel_hold #(
        .WIDTH(36)
    ) u_w_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .valid(s_axi_wvalid),
        .payload({s_axi_wstrb, s_axi_wdata}),
        .ready(s_axi_wready),
        .held(w_held),
        .payload_q(w_beat_q),
        .consume(wr_fire)
    );

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    // one write in flight: a new pair waits until the response is taken
    assign wr_fire = aw_held && w_held && !s_axi_bvalid; // see R04
    assign wr_ctrl = aw_addr_q[ADDR_W-1:2] == off_ctrl[ADDR_W-1:2];
    assign wr_status = aw_addr_q[ADDR_W-1:2] == off_status[ADDR_W-1:2];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_en_q <= `PEC_RST_TX_ENABLE;
            rx_en_q <= `PEC_RST_RX_ENABLE;
            free_q <= `PEC_RST_FREE;
        end
        else if (wr_fire && wr_ctrl)
        begin
            // bit 15 is never stored, so a stray one there has no effect
            if (w_strb_q[1])
            begin
                tx_en_q <= w_data_q[`PEC_BIT_TX_ENABLE]; // see R01
                rx_en_q <= w_data_q[`PEC_BIT_RX_ENABLE];
            end
            if (w_strb_q[0])
            begin
                free_q <= w_data_q[`PEC_BIT_FREE];
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PEC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            // status is read-only: writes are accepted and dropped
            if (wr_ctrl || wr_status)
            begin
                s_axi_bresp <= `PEC_RESP_OKAY;
            end
            else
            begin
                s_axi_bresp <= `PEC_RESP_DECERR;
            end
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    assign ctrl_rd = {16'h0000, 1'b0, tx_en_q, rx_en_q, `PEC_RSVD_ONES_VAL, free_q};
    assign status_rd = {28'h0000000, tx_word_active, halt_req_s,
        state_q == ST_DRAIN, state_q == ST_HALT};

    // reads are served in every halt state
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PEC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1; // see R04
            if (s_axi_araddr[ADDR_W-1:2] == off_ctrl[ADDR_W-1:2])
            begin
                s_axi_rdata <= ctrl_rd;
                s_axi_rresp <= `PEC_RESP_OKAY;
            end
            else if (s_axi_araddr[ADDR_W-1:2] == off_status[ADDR_W-1:2])
            begin
                s_axi_rdata <= status_rd;
                s_axi_rresp <= `PEC_RESP_OKAY;
            end
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `PEC_RESP_DECERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // emulation halt state machine
    // ----------------------------------------------------------------
    // the word counted as in flight is the one on the line when the
    // request lands; no new word starts while draining
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
            begin
                if (halt_req_s && !free_q)
                begin
                    if (tx_word_active)
                    begin
                        state_d = ST_DRAIN; // see R06
                    end
                    else
                    begin
                        state_d = ST_HALT; // see R05
                    end
                end
            end
            ST_DRAIN:
            begin
                if (!halt_req_s || free_q)
                begin
                    state_d = ST_RUN; // see R07
                end
                else if (!tx_word_active)
                begin
                    state_d = ST_HALT; // see R06
                end
            end
            ST_HALT:
            begin
                if (!halt_req_s || free_q)
                begin
                    state_d = ST_RUN; // see R08
                end
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
    end

    assign halted_d = state_d == ST_HALT;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_RUN;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs towards the transmitter and receiver
    // ----------------------------------------------------------------
    // the allow and halted outputs follow the next state so they move with the state register
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_enable <= 1'b0;
            tx_hold_reset <= 1'b1;
            rx_enable <= 1'b0;
            rx_hold_reset <= 1'b1;
            tx_start_allow <= 1'b0;
            rx_allow <= 1'b0;
            event_allow <= 1'b1;
            halted <= 1'b0;
        end
        else
        begin
            tx_enable <= tx_en_q; // see R02
            tx_hold_reset <= !tx_en_q; // see R02
            rx_enable <= rx_en_q; // see R03
            rx_hold_reset <= !rx_en_q; // see R03
            tx_start_allow <= tx_en_q && (state_d == ST_RUN); // see R04
            rx_allow <= rx_en_q && !halted_d; // see R04
            event_allow <= !halted_d; // see R07
            halted <= halted_d; // see R04
        end
    end

endmodule // uart_pwr_emu_ctrl

`default_nettype wire

// ==== hw/uart_pwr_emu_defines.vh ====
// constants for the uart power and emulation control block
// assumes: included by bare name from the design files under hw/
//
// Notes on behaviour
// R01: software always writes zero into the reserved bit above transmitter enable.
// R02: transmitter enable low keeps transmitter disabled and in reset; high releases it.
// R03: receiver enable low keeps receiver disabled and in reset; high releases it.
// R04: halted block still serves registers but starts no transfer, interrupt or event.
// R05: free bit clear and transmitter idle: halt at once on a halt request.
// R06: free bit clear and word in flight: finish that word, then halt.
// R07: free bit set: halt requests are ignored, operation stays normal.
// R08: dropping the halt request ends the halt and resumes normal operation.
`ifndef UART_PWR_EMU_DEFINES_VH
`define UART_PWR_EMU_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PEC_OFFSET_CTRL 12'h000
`define PEC_OFFSET_STATUS 12'h004

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PEC_BIT_RSVD_ZERO 15
`define PEC_BIT_TX_ENABLE 14
`define PEC_BIT_RX_ENABLE 13
`define PEC_RSVD_ONES_HI 12
`define PEC_RSVD_ONES_LO 1
`define PEC_BIT_FREE 0
`define PEC_RST_TX_ENABLE 1'b0
`define PEC_RST_RX_ENABLE 1'b0
`define PEC_RST_FREE 1'b0
`define PEC_RSVD_ONES_VAL 12'hfff

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define PEC_STS_HALTED 0
`define PEC_STS_DRAINING 1
`define PEC_STS_HALT_REQ 2
`define PEC_STS_TX_ACTIVE 3

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define PEC_RESP_OKAY 2'b00
`define PEC_RESP_DECERR 2'b11

`endif

// ==== hw/sync_2ff.v ====
// two-flop level synchroniser
// assumes: input is a level from another clock domain or a pin
`timescale 1ns/1ps
`default_nettype none

module sync_2ff (
    input wire aclk,
    input wire aresetn,
    input wire async_in,
    output reg sync_out
);

    reg meta_q;

    // first flop feeds only the second one
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // sync_2ff

`default_nettype wire

// ==== hw/axil_channel_hold.v ====
// holds one beat of an axi channel until the consumer takes it
// assumes: consume is only raised while held is high
`timescale 1ns/1ps
`default_nettype none

module axil_channel_hold #(
    parameter WIDTH = 32
) (
    input wire aclk,
    input wire aresetn,
    input wire valid,
    input wire [WIDTH-1:0] payload,
    output reg ready,
    output reg held,
    output reg [WIDTH-1:0] payload_q,
    input wire consume
);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ready <= 1'b1;
            held <= 1'b0;
            payload_q <= {WIDTH{1'b0}};
        end
        else if (valid && ready)
        begin
            ready <= 1'b0;
            held <= 1'b1;
            payload_q <= payload;
        end
        else if (consume)
        begin
            ready <= 1'b1;
            held <= 1'b0;
        end
    end

endmodule // axil_channel_hold

`default_nettype wire

// ==== tb/uart_pwr_emu_ctrl_props.sv ====
// checker for the uart power and emulation control block
// assumes: bound to uart_pwr_emu_ctrl, watches its ports only
`timescale 1ns/1ps
`default_nettype none

module uart_pwr_emu_ctrl_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic emu_halt_req,
    input wire logic tx_word_active,
    input wire logic tx_enable,
    input wire logic tx_hold_reset,
    input wire logic rx_enable,
    input wire logic rx_hold_reset,
    input wire logic tx_start_allow,
    input wire logic rx_allow,
    input wire logic event_allow,
    input wire logic halted
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // halt, enable and read answer relations
    // ----
    // request must stay low through both sync flops and the state flop
    sequence s_req_low;
        !emu_halt_req [*4];
    endsequence
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_tx_gate;
        tx_hold_reset |-> !tx_enable && !tx_start_allow;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx active in reset");
    property p_rx_gate;
        rx_hold_reset |-> !rx_enable && !rx_allow;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx active in reset");
    property p_halt_gate;
        halted |-> !event_allow && !rx_allow && !tx_start_allow;
    endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("halted but allowed");
    property p_read_ans;
        s_ar_taken |=> s_axi_rvalid;
    endproperty
    a_read_ans: assert property (p_read_ans) else $error("read not answered");
    property p_event;
        $fell(event_allow) |-> $past(emu_halt_req, 3);
    endproperty
    a_event: assert property (p_event) else $error("events blocked without request");
    property p_halt_src;
        $rose(halted) |-> $past(emu_halt_req, 3);
    endproperty
    a_halt_src: assert property (p_halt_src) else $error("halt without request");
    property p_drain;
        $rose(halted) |-> !$past(tx_word_active);
    endproperty
    a_drain: assert property (p_drain) else $error("halt during a word");
    property p_resume;
        s_req_low |-> !halted;
    endproperty
    a_resume: assert property (p_resume) else $error("halt outlived request");
endmodule // uart_pwr_emu_ctrl_props

bind uart_pwr_emu_ctrl uart_pwr_emu_ctrl_props uart_pwr_emu_ctrl_props_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .emu_halt_req(emu_halt_req),
    .tx_word_active(tx_word_active),
    .tx_enable(tx_enable),
    .tx_hold_reset(tx_hold_reset),
    .rx_enable(rx_enable),
    .rx_hold_reset(rx_hold_reset),
    .tx_start_allow(tx_start_allow),
    .rx_allow(rx_allow),
    .event_allow(event_allow),
    .halted(halted)
);

`default_nettype wire

// ==== tb/tx_word_model.sv ====
// transmitter stand-in: sends one word per tx_go pulse when allowed
// assumes: tx_go is driven on aclk
`timescale 1ns/1ps
`default_nettype none

module tx_word_model #(
    parameter int WORD_CYCLES = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_go,
    input wire logic tx_start_allow,
    output logic tx_word_active
);
    int cnt_q;
    assign tx_word_active = (cnt_q != 0);
    // a word once begun always runs to its end
    always @(posedge aclk)
    begin
        if (!aresetn)
            cnt_q <= 0;
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
        else if (tx_go && tx_start_allow)
            cnt_q <= WORD_CYCLES;
    end
endmodule // tx_word_model

`default_nettype wire

// ==== tb/tb.sv ====
// testbench for the uart power and emulation control block
// assumes: axi4-lite master tasks, transmitter stand-in, 40 MHz aclk
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic aclk, aresetn, tx_go, emu_halt_req, tx_word_active;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic tx_enable, tx_hold_reset, rx_enable, rx_hold_reset;
    logic tx_start_allow, rx_allow, event_allow, halted;
    int fail_count, compares;

    uart_pwr_emu_ctrl uart_pwr_emu_ctrl_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .emu_halt_req(emu_halt_req),
        .tx_word_active(tx_word_active),
        .tx_enable(tx_enable),
        .tx_hold_reset(tx_hold_reset),
        .rx_enable(rx_enable),
        .rx_hold_reset(rx_hold_reset),
        .tx_start_allow(tx_start_allow),
        .rx_allow(rx_allow),
        .event_allow(event_allow),
        .halted(halted)
    );
    tx_word_model tx_word_model_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .tx_go(tx_go),
        .tx_start_allow(tx_start_allow),
        .tx_word_active(tx_word_active)
    );

    // ----
    // bus and check tasks
    // ----
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic lim(input int n);
        if (n >= 60)
        begin
            fail_count++;
            $display("BAD at %0t: no answer", $time);
            summarize();
        end
    endtask
    task automatic edges(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid && n < 60);
        s_axi_bready <= 1'h0;
        lim(n);
        chk(s_axi_bresp, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid && n < 60);
        s_axi_rready <= 1'h0;
        lim(n);
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
    endtask

    initial
    begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    initial
    begin
        int n;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0;
        {s_axi_wdata, s_axi_wstrb, tx_go, emu_halt_req} = 38'h0;
        aresetn = 1'h0;
        fail_count = 0;
        compares = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(12'h000, 32'h00001ffe, 2'h0);
        chk({tx_enable, tx_hold_reset, rx_enable, rx_hold_reset, event_allow, halted}, 6'h16);
        wr(12'h000, 32'h00006001, 4'hf, 2'h0);
        rd(12'h000, 32'h00007fff, 2'h0);
        edges(2);
        chk({tx_enable, tx_hold_reset, rx_enable, rx_hold_reset, tx_start_allow, rx_allow}, 6'h2b);
        wr(12'h000, 32'h00000000, 4'h1, 2'h0);
        rd(12'h000, 32'h00007ffe, 2'h0);
        wr(12'h000, 32'h00002000, 4'h2, 2'h0);
        rd(12'h000, 32'h00003ffe, 2'h0);
        edges(2);
        chk({tx_hold_reset, tx_start_allow, rx_allow}, 3'h5);
        wr(12'h000, 32'h00006000, 4'hf, 2'h0);
        wr(12'h008, 32'h00006001, 4'hf, 2'h3);
        rd(12'h008, 32'h00000000, 2'h3);
        wr(12'h004, 32'h0000000f, 4'hf, 2'h0);
        rd(12'h004, 32'h00000000, 2'h0);
        // idle transmitter: halt lands on the third edge
        emu_halt_req <= 1'h1;
        edges(2);
        chk(halted, 1'h0);
        edges(1);
        chk({halted, event_allow, rx_allow, tx_start_allow}, 4'h8);
        rd(12'h004, 32'h00000005, 2'h0);
        wr(12'h000, 32'h00006000, 4'hf, 2'h0);
        tx_go <= 1'h1;
        edges(1);
        chk(tx_word_active, 1'h0);
        @(posedge aclk);
        tx_go <= 1'h0;
        emu_halt_req <= 1'h0;
        edges(3);
        chk({halted, event_allow, rx_allow, tx_start_allow}, 4'h7);
        // word in flight: drain first, then halt
        @(posedge aclk);
        tx_go <= 1'h1;
        @(posedge aclk);
        tx_go <= 1'h0;
        emu_halt_req <= 1'h1;
        edges(3);
        chk({halted, tx_word_active, tx_start_allow, event_allow}, 4'h5);
        rd(12'h004, 32'h0000000e, 2'h0);
        for (n = 0; n < 60 && halted !== 1'h1; n++)
            edges(1);
        lim(n);
        chk(tx_word_active, 1'h0);
        @(posedge aclk);
        emu_halt_req <= 1'h0;
        wr(12'h000, 32'h00006001, 4'hf, 2'h0);
        emu_halt_req <= 1'h1;
        edges(6);
        chk({halted, event_allow, tx_start_allow}, 3'h3);
        // free cleared under a standing request halts; set again resumes
        wr(12'h000, 32'h00006000, 4'hf, 2'h0);
        edges(1);
        chk({halted, event_allow}, 2'h2);
        wr(12'h000, 32'h00006001, 4'hf, 2'h0);
        edges(1);
        chk({halted, event_allow, tx_start_allow}, 3'h3);
        summarize();
    end
endmodule // tb

`default_nettype wire
